// file: hdl/weigh_status_regs.svh
// Register indexes, field positions, codes and reset values of the weigh status bank.
`ifndef WEIGH_STATUS_REGS_SVH
`define WEIGH_STATUS_REGS_SVH

// Register indexes on the cyclic read port.
`define IDX_COMMAND_LEVEL_MIRROR   8'h02
`define IDX_PULSE_COMMAND_MIRROR   8'h03
`define IDX_SCALING_AND_FAULT_INFO 8'h04
`define IDX_PRODUCT_REVISION_INFO  8'h05

// Command select codes: level set base, level clear offset, pulse base.
`define CMD_LEVEL_BASE   8'h50
`define CMD_LEVEL_LAST   8'h5D
`define CMD_UNUSED_LEVEL 8'h58
`define CMD_CLEAR_OFFSET 8'h80
`define CMD_PULSE_BASE   8'h70
`define CMD_PULSE_LAST   8'h7D
`define CMD_UNUSED_PULSE 8'h78
`define CMD_COUNT        14
`define CMD_CLEAR_FAULT_BIT 9

// Field positions in the mirror and info words.
`define MIRROR_LOW_LSB   16
`define MIRROR_HIGH_LSB  25
`define INFO_UNIT_LSB    8
`define INFO_STEP_LSB    16
`define INFO_FAULT_LSB   24

// Weight unit codes.
`define UNIT_MILLIGRAM 8'h01
`define UNIT_GRAM      8'h02
`define UNIT_KILOGRAM  8'h03
`define UNIT_TON       8'h04
`define UNIT_POUND     8'h05
`define UNIT_LITER     8'h06

// Step width codes, equal to the increment itself.
`define STEP_1  8'h01
`define STEP_2  8'h02
`define STEP_5  8'h05
`define STEP_10 8'h0A
`define STEP_20 8'h14
`define STEP_50 8'h32

// Fault codes loaded by the block itself.
`define FAULT_RANGE      8'h23
`define FAULT_CAL_LOCKED 8'h28
`define FAULT_NOT_IN_CAL 8'h29

// Reset values.
`define RESET_WORD  32'h0000_0000
`define RESET_FAULT 8'h00

`endif

// file: hdl/weigh_status_pkg.sv
// Types shared by the weigh status bank modules.
package weigh_status_pkg;

  typedef logic [7:0]  byte_type;
  typedef logic [31:0] word_type;
  typedef logic [13:0] cmd_vec_type;

  // Whole state of the register bank.
  typedef struct packed {
    cmd_vec_type levelCmd;
    cmd_vec_type actionStart;
    logic        commandFaultFlag;
    byte_type    recentFaultCode;
    logic        rdValid;
    word_type    rdData;
  } bank_state_type;

  // Whole state of the pin filter.
  typedef struct packed {
    logic [2:0] stage;
    logic       level;
  } filter_state_type;

endpackage : weigh_status_pkg

// file: hdl/pin_level_filter.sv
// Three-stage synchroniser that accepts a pin level once two late stages agree.
`timescale 1ns/10ps
module pin_level_filter (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic pinRaw,
  output logic      pinLevel
);
  import weigh_status_pkg::*;

  filter_state_type st_ff;
  filter_state_type nxt_st;

  // Stage 0 feeds only stage 1; the level moves when stages 1 and 2 agree.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage = {st_ff.stage[1:0], pinRaw};
    if (st_ff.stage[1] == st_ff.stage[2]) begin
      nxt_st.level = st_ff.stage[2];
    end
  end

  // Reset to unlocked levels.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pinLevel = st_ff.level;

endmodule : pin_level_filter

// file: hdl/weigh_status_registers.sv
// Read-only status register bank of the weighing transmitter with command mirrors and faults.
//
// Contract
// - Level command bits mirrored in status word.
// - Transition command status word always reads zero.
// - Info word packs exponent, unit, step, fault.
// - Unit codes one to six, milligram to liter.
// - Out-of-range weight loads fault code 35.
// - Locked calibration switch loads fault code 40.
// - Calibration step outside calibration loads 41.
// - Identity word: type MSB first, major, minor.
// - Failure sets fault flag, held until cleared.
// - Level command acts on rising edge.
// - Transition command self-clears, acts once.
`timescale 1ns/10ps
`include "weigh_status_regs.svh"
module weigh_status_registers #(
  parameter logic [15:0] TYPE_NUMBER   = 16'h0A5C, // Arbitrary value.
  parameter logic [7:0]  MAJOR_RELEASE = 8'h01,    // Arbitrary value.
  parameter logic [7:0]  MINOR_RELEASE = 8'h00     // Arbitrary value.
) (
  input  wire logic                         core_clk,
  input  wire logic                         arst_n,
  input  wire logic                         rdReq,
  input  wire weigh_status_pkg::byte_type   rdIndex,
  output logic                              rdValid,
  output weigh_status_pkg::word_type        rdData,
  input  wire logic                         cmdWrValid,
  input  wire weigh_status_pkg::byte_type   cmdWrSelect,
  output weigh_status_pkg::cmd_vec_type     actionStart,
  output weigh_status_pkg::cmd_vec_type     levelCmdState,
  input  wire weigh_status_pkg::byte_type   decimalExponent,
  input  wire logic [2:0]                   unitSel,
  input  wire logic [2:0]                   stepSel,
  input  wire logic                         calLockPin,
  input  wire logic                         calModeActive,
  input  wire logic                         calStepReq,
  input  wire logic                         rangeFail,
  input  wire logic                         faultValid,
  input  wire weigh_status_pkg::byte_type   faultCode,
  output logic                              commandFaultFlag,
  output weigh_status_pkg::byte_type        recentFaultCode
);
  import weigh_status_pkg::*;

  bank_state_type st_ff;
  bank_state_type nxt_st;
  logic           calLocked;
  byte_type       unitCode;
  byte_type       stepCode;
  word_type       levelMirror;
  word_type       infoWord;
  cmd_vec_type    setMask;
  cmd_vec_type    clrMask;
  cmd_vec_type    pulseMask;
  byte_type       cmdOffset;
  logic           faultEvent;
  byte_type       faultNext;

  // The lock switch is a pin and must be filtered before it decides anything.
  pin_level_filter u_lock_filter (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pinRaw   (calLockPin),
    .pinLevel (calLocked)
  );

  // Unit selection to unit code; an unknown selection reports zero.
  always_comb begin
    unique case (unitSel)
      3'd0:    unitCode = `UNIT_MILLIGRAM;
      3'd1:    unitCode = `UNIT_GRAM;
      3'd2:    unitCode = `UNIT_KILOGRAM;
      3'd3:    unitCode = `UNIT_TON;
      3'd4:    unitCode = `UNIT_POUND;
      3'd5:    unitCode = `UNIT_LITER;
      default: unitCode = 8'h00;
    endcase
  end

  // Step selection to step code; the byte carries the increment itself.
  always_comb begin
    unique case (stepSel)
      3'd0:    stepCode = `STEP_1;
      3'd1:    stepCode = `STEP_2;
      3'd2:    stepCode = `STEP_5;
      3'd3:    stepCode = `STEP_10;
      3'd4:    stepCode = `STEP_20;
      3'd5:    stepCode = `STEP_50;
      default: stepCode = 8'h00;
    endcase
  end

  // Decode one command write into set, clear and pulse masks.
  always_comb begin
    setMask   = '0;
    clrMask   = '0;
    pulseMask = '0;
    cmdOffset = 8'h00;
    if (cmdWrValid) begin
      if (cmdWrSelect >= `CMD_LEVEL_BASE && cmdWrSelect <= `CMD_LEVEL_LAST
          && cmdWrSelect != `CMD_UNUSED_LEVEL) begin
        cmdOffset = cmdWrSelect - `CMD_LEVEL_BASE;
        setMask[cmdOffset[3:0]] = 1'b1;
      end else if (cmdWrSelect >= (`CMD_LEVEL_BASE + `CMD_CLEAR_OFFSET)
          && cmdWrSelect <= (`CMD_LEVEL_LAST + `CMD_CLEAR_OFFSET)
          && cmdWrSelect != (`CMD_UNUSED_LEVEL + `CMD_CLEAR_OFFSET)) begin
        cmdOffset = cmdWrSelect - (`CMD_LEVEL_BASE + `CMD_CLEAR_OFFSET);
        clrMask[cmdOffset[3:0]] = 1'b1;
      end else if (cmdWrSelect >= `CMD_PULSE_BASE && cmdWrSelect <= `CMD_PULSE_LAST
          && cmdWrSelect != `CMD_UNUSED_PULSE) begin
        cmdOffset = cmdWrSelect - `CMD_PULSE_BASE;
        pulseMask[cmdOffset[3:0]] = 1'b1;
      end
    end
  end

  // Fault source priority: lock, then calibration mode, then range, then others.
  always_comb begin
    faultEvent = 1'b1;
    faultNext  = st_ff.recentFaultCode;
    if (calStepReq && calLocked) begin
      faultNext = `FAULT_CAL_LOCKED;
    end else if (calStepReq && !calModeActive) begin
      faultNext = `FAULT_NOT_IN_CAL;
    end else if (rangeFail) begin
      faultNext = `FAULT_RANGE;
    end else if (faultValid) begin
      faultNext = faultCode;
    end else begin
      faultEvent = 1'b0;
    end
  end

  // Status words assembled from live state.
  always_comb begin
    levelMirror = `RESET_WORD;
    levelMirror[`MIRROR_LOW_LSB +: 8]  = st_ff.levelCmd[7:0];
    levelMirror[`MIRROR_HIGH_LSB +: 5] = st_ff.levelCmd[13:9];
    infoWord = {st_ff.recentFaultCode, stepCode, unitCode, decimalExponent};
  end

  // Next state of the whole bank.
  always_comb begin
    nxt_st = st_ff;
    // Only a 0 to 1 change of a level bit starts its action.
    nxt_st.levelCmd    = (st_ff.levelCmd | setMask) & ~clrMask;
    nxt_st.actionStart = (setMask & ~st_ff.levelCmd) | pulseMask;
    // A fault raised in the clearing cycle survives; set wins over clear.
    if (faultEvent) begin
      nxt_st.commandFaultFlag = 1'b1;
      nxt_st.recentFaultCode  = faultNext;
    end else if (st_ff.actionStart[`CMD_CLEAR_FAULT_BIT]) begin
      nxt_st.commandFaultFlag = 1'b0;
    end
    nxt_st.rdValid = rdReq;
    nxt_st.rdData  = `RESET_WORD;
    if (rdReq) begin
      unique case (rdIndex)
        `IDX_COMMAND_LEVEL_MIRROR:   nxt_st.rdData = levelMirror;
        `IDX_PULSE_COMMAND_MIRROR:   nxt_st.rdData = `RESET_WORD;
        `IDX_SCALING_AND_FAULT_INFO: nxt_st.rdData = infoWord;
        `IDX_PRODUCT_REVISION_INFO:  nxt_st.rdData = {MINOR_RELEASE, MAJOR_RELEASE,
                                                      TYPE_NUMBER[7:0],
                                                      TYPE_NUMBER[15:8]};
        default:                     nxt_st.rdData = `RESET_WORD;
      endcase
    end
  end

  // Single register stage for all state; the fault code survives until overwritten.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdValid          = st_ff.rdValid;
  assign rdData           = st_ff.rdData;
  assign actionStart      = st_ff.actionStart;
  assign levelCmdState    = st_ff.levelCmd;
  assign commandFaultFlag = st_ff.commandFaultFlag;
  assign recentFaultCode  = st_ff.recentFaultCode;

  // Checks beside the logic they guard.
  property p_level_mirror;
    @(posedge core_clk) disable iff (!arst_n)
    rdReq && rdIndex == `IDX_COMMAND_LEVEL_MIRROR
      |=> rdValid && rdData[23:16] == $past(st_ff.levelCmd[7:0])
          && rdData[29:25] == $past(st_ff.levelCmd[13:9]) && rdData[15:0] == 16'h0000;
  endproperty
  a_level_mirror: assert property (p_level_mirror) else $error("level mirror wrong");

  property p_pulse_zero;
    @(posedge core_clk) disable iff (!arst_n)
    rdReq && rdIndex == `IDX_PULSE_COMMAND_MIRROR |=> rdValid && rdData == 32'h0000_0000;
  endproperty
  a_pulse_zero: assert property (p_pulse_zero) else $error("pulse mirror not zero");

  property p_info_pack;
    @(posedge core_clk) disable iff (!arst_n)
    rdReq && rdIndex == `IDX_SCALING_AND_FAULT_INFO
      |=> rdData[7:0] == $past(decimalExponent) && rdData[31:24] == $past(recentFaultCode);
  endproperty
  a_info_pack: assert property (p_info_pack) else $error("info word packing wrong");

  property p_unit_code;
    @(posedge core_clk) disable iff (!arst_n)
    rdReq && rdIndex == `IDX_SCALING_AND_FAULT_INFO && unitSel < 3'd6
      |=> rdData[15:8] == {5'b00000, $past(unitSel)} + 8'h01;
  endproperty
  a_unit_code: assert property (p_unit_code) else $error("unit code wrong");

  property p_range_fault;
    @(posedge core_clk) disable iff (!arst_n)
    rangeFail && !calStepReq |=> recentFaultCode == 8'h23 && commandFaultFlag;
  endproperty
  a_range_fault: assert property (p_range_fault) else $error("range fault code wrong");

  property p_lock_fault;
    @(posedge core_clk) disable iff (!arst_n)
    calStepReq && calLocked |=> recentFaultCode == 8'h28;
  endproperty
  a_lock_fault: assert property (p_lock_fault) else $error("lock fault code wrong");

  property p_cal_fault;
    @(posedge core_clk) disable iff (!arst_n)
    calStepReq && !calLocked && !calModeActive |=> recentFaultCode == 8'h29;
  endproperty
  a_cal_fault: assert property (p_cal_fault) else $error("calibration fault code wrong");

  property p_fault_hold;
    @(posedge core_clk) disable iff (!arst_n)
    commandFaultFlag && !actionStart[9] && !faultEvent
      |=> commandFaultFlag && $stable(recentFaultCode);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault flag not held");

  property p_level_edge;
    @(posedge core_clk) disable iff (!arst_n)
    cmdWrValid && cmdWrSelect == 8'h50 && !levelCmdState[0]
      |=> actionStart[0] && levelCmdState[0] ##1 !actionStart[0] || cmdWrValid;
  endproperty
  a_level_edge: assert property (p_level_edge) else $error("level command edge missed");

  property p_pulse_once;
    @(posedge core_clk) disable iff (!arst_n)
    cmdWrValid && cmdWrSelect == 8'h70
      |=> actionStart[0] && $stable(levelCmdState);
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("pulse command not once");

  property p_step_code;
    @(posedge core_clk) disable iff (!arst_n)
    rdReq && rdIndex == `IDX_SCALING_AND_FAULT_INFO && stepSel == 3'd3
      |=> rdData[23:16] == 8'h0A;
  endproperty
  a_step_code: assert property (p_step_code) else $error("step code wrong");

  property p_ident;
    @(posedge core_clk) disable iff (!arst_n)
    rdReq && rdIndex == `IDX_PRODUCT_REVISION_INFO
      |=> rdData == {MINOR_RELEASE, MAJOR_RELEASE, TYPE_NUMBER[7:0], TYPE_NUMBER[15:8]};
  endproperty
  a_ident: assert property (p_ident) else $error("identity word wrong");

  property p_other_fault;
    @(posedge core_clk) disable iff (!arst_n)
    faultValid && !rangeFail && !calStepReq |=> recentFaultCode == $past(faultCode);
  endproperty
  a_other_fault: assert property (p_other_fault) else $error("fault code not passed");

endmodule : weigh_status_registers

// file: verif/fieldbus_master_model.sv
// Behavioural fieldbus master that reads status words and writes command selects.
`timescale 1ns/10ps
module fieldbus_master_model (
  input  wire logic                          core_clk,
  output logic                               rdReq,
  output weigh_status_pkg::byte_type         rdIndex,
  input  wire logic                          rdValid,
  input  wire weigh_status_pkg::word_type    rdData,
  output logic                               cmdWrValid,
  output weigh_status_pkg::byte_type         cmdWrSelect,
  input  wire weigh_status_pkg::cmd_vec_type actionStart,
  input  wire weigh_status_pkg::cmd_vec_type levelCmdState
);
  import weigh_status_pkg::*;

  // Idle bus at time zero.
  initial begin
    rdReq       = 1'b0;
    rdIndex     = 8'h00;
    cmdWrValid  = 1'b0;
    cmdWrSelect = 8'h00;
  end

  // One-cycle read; a released index shows its inverse so stale values never look valid.
  task automatic readReg(input byte_type idx, output logic valid, output word_type data);
    @(posedge core_clk);
    #1;
    rdReq   = 1'b1;
    rdIndex = idx;
    @(posedge core_clk);
    #1;
    rdReq   = 1'b0;
    rdIndex = ~idx;
    valid   = rdValid;
    data    = rdData;
  endtask : readReg

  // One-cycle command write; set codes and their +128 clear codes share this path, and
  // a level bit stays at 1 until the caller writes its clear code.
  task automatic writeCmd(input byte_type sel, output cmd_vec_type pulse,
                          output cmd_vec_type level);
    @(posedge core_clk);
    #1;
    cmdWrValid  = 1'b1;
    cmdWrSelect = sel;
    @(posedge core_clk);
    #1;
    cmdWrValid  = 1'b0;
    cmdWrSelect = ~sel;
    pulse       = actionStart;
    level       = levelCmdState;
  endtask : writeCmd
endmodule : fieldbus_master_model

// file: verif/weigh_status_registers_test.sv
// Self-checking testbench of the weigh status register bank.
`timescale 1ns/10ps
`include "weigh_status_regs.svh"
module weigh_status_registers_test;
  import weigh_status_pkg::*;

  localparam logic [15:0] TYPE_VAL = 16'h1B2E; // Arbitrary value.
  localparam byte_type    MAJ_VAL  = 8'h07;    // Arbitrary value.
  localparam byte_type    MIN_VAL  = 8'h3C;    // Arbitrary value.

  typedef struct {
    byte_type   decimal_exponent;
    logic [2:0] unit;
    logic [2:0] step;
    word_type   want;
  } info_row_type;

  logic        core_clk, arst_n, rdReq, rdValid, cmdWrValid, calLockPin, calModeActive;
  logic        calStepReq, rangeFail, faultValid, commandFaultFlag;
  byte_type    rdIndex, cmdWrSelect, decimalExponent, faultCode, recentFaultCode;
  word_type    rdData;
  cmd_vec_type actionStart, levelCmdState, pulse, level;
  logic [2:0]  unitSel, stepSel;
  int          errors, num_checks;

  // Info word cases; the last row uses out-of-range selects, which give code 0.
  info_row_type rows [7] = '{
    '{8'h00, 3'd0, 3'd0, 32'h0001_0100}, '{8'h01, 3'd1, 3'd1, 32'h0002_0201},
    '{8'h02, 3'd2, 3'd2, 32'h0005_0302}, '{8'h03, 3'd3, 3'd3, 32'h000A_0403},
    '{8'hFF, 3'd4, 3'd4, 32'h0014_05FF}, '{8'h00, 3'd5, 3'd5, 32'h0032_0600},
    '{8'h80, 3'd6, 3'd7, 32'h0000_0080}};
  byte_type codes [4] = '{8'h1F, 8'h21, 8'h68, 8'h6C};

  weigh_status_registers #(.TYPE_NUMBER(TYPE_VAL), .MAJOR_RELEASE(MAJ_VAL),
    .MINOR_RELEASE(MIN_VAL)) DUT (.core_clk(core_clk), .arst_n(arst_n), .rdReq(rdReq),
    .rdIndex(rdIndex), .rdValid(rdValid), .rdData(rdData), .cmdWrValid(cmdWrValid),
    .cmdWrSelect(cmdWrSelect), .actionStart(actionStart), .levelCmdState(levelCmdState),
    .decimalExponent(decimalExponent), .unitSel(unitSel), .stepSel(stepSel),
    .calLockPin(calLockPin), .calModeActive(calModeActive), .calStepReq(calStepReq),
    .rangeFail(rangeFail), .faultValid(faultValid), .faultCode(faultCode),
    .commandFaultFlag(commandFaultFlag), .recentFaultCode(recentFaultCode));

  fieldbus_master_model master (.core_clk(core_clk), .rdReq(rdReq), .rdIndex(rdIndex),
    .rdValid(rdValid), .rdData(rdData), .cmdWrValid(cmdWrValid), .cmdWrSelect(cmdWrSelect),
    .actionStart(actionStart), .levelCmdState(levelCmdState));

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input word_type want, input word_type got);
    num_checks++;
    if (got !== want) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, want, got);
    end
  endtask : check

  // A read must be answered, so the valid bit is compared beside the data.
  task automatic rd(input byte_type idx, input word_type want);
    logic     valid;
    word_type data;
    master.readReg(idx, valid, data);
    check("read valid", 32'h0000_0001, word_type'(valid));
    check("read data", want, data);
  endtask : rd

  // Pulses the selected fault sources for a single cycle.
  task automatic raise(input logic cal, input logic rng, input logic fv, input byte_type code);
    @(posedge core_clk);
    #1;
    calStepReq = cal;
    rangeFail  = rng;
    faultValid = fv;
    faultCode  = code;
    @(posedge core_clk);
    #1;
    {calStepReq, rangeFail, faultValid} = 3'b000;
  endtask : raise

  // Flag, code port and the fault byte of the info word must all agree; the lower three
  // bytes assume exponent 0, unit select 5 and step select 5, the bench's resting setup.
  task automatic fault_is(input logic flag, input byte_type code);
    check("fault flag", word_type'(flag), word_type'(commandFaultFlag));
    check("fault code", word_type'(code), word_type'(recentFaultCode));
    rd(`IDX_SCALING_AND_FAULT_INFO, {code, 24'h32_0600});
  endtask : fault_is

  task automatic finish_test();
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    finish_test();
  end

  initial begin
    arst_n = 1'b0;
    {decimalExponent, faultCode} = 16'h0000;
    {unitSel, stepSel} = 6'b101101;
    {calLockPin, calStepReq, rangeFail, faultValid} = 4'b0000;
    calModeActive = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 arst_n = 1'b1;
    fault_is(1'b0, `RESET_FAULT);
    rd(`IDX_COMMAND_LEVEL_MIRROR, `RESET_WORD);
    rd(`IDX_PULSE_COMMAND_MIRROR, `RESET_WORD);
    // Ordinary info word cases.
    foreach (rows[i]) begin
      decimalExponent = rows[i].decimal_exponent;
      unitSel = rows[i].unit;
      stepSel = rows[i].step;
      rd(`IDX_SCALING_AND_FAULT_INFO, rows[i].want);
    end
    // Back to the resting setup that the fault checks expect.
    decimalExponent = 8'h00;
    unitSel = 3'd5;
    stepSel = 3'd5;
    rd(`IDX_PRODUCT_REVISION_INFO, {MIN_VAL, MAJ_VAL, TYPE_VAL[7:0], TYPE_VAL[15:8]});
    rd(8'h06, 32'h0000_0000);
    // Level commands: one pulse on the rising edge only, mirrored, then cleared.
    for (int n = 0; n < `CMD_COUNT; n++) begin
      if (n == 8) continue;
      master.writeCmd(byte_type'(`CMD_LEVEL_BASE + n), pulse, level);
      check("level pulse", word_type'(1) << n, word_type'(pulse));
      master.writeCmd(byte_type'(`CMD_LEVEL_BASE + n), pulse, level);
      check("repeat pulse", 32'h0000_0000, word_type'(pulse));
      rd(`IDX_COMMAND_LEVEL_MIRROR, word_type'(1) << (16 + n));
      master.writeCmd(byte_type'(`CMD_LEVEL_BASE + `CMD_CLEAR_OFFSET + n), pulse, level);
      check("level cleared", 32'h0000_0000, word_type'(level | pulse));
    end
    // Pulse commands: one action, no level left behind.
    for (int n = 0; n < `CMD_COUNT; n++) begin
      if (n == 8) continue;
      master.writeCmd(byte_type'(`CMD_PULSE_BASE + n), pulse, level);
      check("pulse action", word_type'(1) << n, word_type'(pulse));
      check("pulse level", 32'h0000_0000, word_type'(level));
      rd(`IDX_PULSE_COMMAND_MIRROR, 32'h0000_0000);
    end
    master.writeCmd(`CMD_UNUSED_LEVEL, pulse, level);
    check("unused level code", 32'h0000_0000, word_type'(pulse | level));
    master.writeCmd(`CMD_UNUSED_PULSE, pulse, level);
    check("unused pulse code", 32'h0000_0000, word_type'(pulse | level));
    master.writeCmd(8'hD8, pulse, level);
    check("unused clear code", 32'h0000_0000, word_type'(pulse | level));
    // Range fault is held until the clear command, and its code stays.
    raise(1'b0, 1'b1, 1'b0, 8'h00);
    fault_is(1'b1, `FAULT_RANGE);
    master.writeCmd(byte_type'(`CMD_PULSE_BASE + `CMD_CLEAR_FAULT_BIT), pulse, level);
    check("flag before clear", 32'h0000_0001, word_type'(commandFaultFlag));
    @(posedge core_clk);
    #1;
    fault_is(1'b0, `FAULT_RANGE);
    // Locked switch outranks a range fault in the same cycle; cleared by level code.
    calLockPin = 1'b1;
    repeat (6) @(posedge core_clk);
    raise(1'b1, 1'b1, 1'b0, 8'h00);
    fault_is(1'b1, `FAULT_CAL_LOCKED);
    master.writeCmd(byte_type'(`CMD_LEVEL_BASE + `CMD_CLEAR_FAULT_BIT), pulse, level);
    master.writeCmd(byte_type'(`CMD_LEVEL_BASE + `CMD_CLEAR_OFFSET + 9), pulse, level);
    fault_is(1'b0, `FAULT_CAL_LOCKED);
    calLockPin = 1'b0;
    calModeActive = 1'b0;
    repeat (6) @(posedge core_clk);
    raise(1'b1, 1'b0, 1'b0, 8'h00);
    fault_is(1'b1, `FAULT_NOT_IN_CAL);
    master.writeCmd(byte_type'(`CMD_PULSE_BASE + `CMD_CLEAR_FAULT_BIT), pulse, level);
    calModeActive = 1'b1;
    raise(1'b1, 1'b0, 1'b0, 8'h00);
    fault_is(1'b0, `FAULT_NOT_IN_CAL);
    foreach (codes[i]) begin
      raise(1'b0, 1'b0, 1'b1, codes[i]);
      fault_is(1'b1, codes[i]);
    end
    // Reset in mid-run drops level bits and the fault state at once.
    master.writeCmd(`CMD_LEVEL_BASE, pulse, level);
    arst_n = 1'b0;
    #1;
    check("reset state", 32'h0000_0000, {17'h0_0000, levelCmdState, commandFaultFlag});
    @(posedge core_clk);
    #1 arst_n = 1'b1;
    fault_is(1'b0, `RESET_FAULT);
    finish_test();
  end
endmodule : weigh_status_registers_test
